// ===== verilog/touch_ctl_cfg.svh
// Constants for the resistive touch matrix control block
`ifndef TOUCH_CTL_CFG_SVH
`define TOUCH_CTL_CFG_SVH
// Register byte addresses
`define TC_ADDR_CTRL 12'h000
`define TC_ADDR_ADCSEL 12'h004
`define TC_ADDR_STATUS 12'h008
`define TC_ADDR_STBY 12'h00C
// Control register field positions
`define TC_XP_POW 0
`define TC_XP_GND 1
`define TC_XN_POW 2
`define TC_XN_GND 3
`define TC_YP_POW 4
`define TC_YP_GND 5
`define TC_YN_POW 6
`define TC_YN_GND 7
`define TC_MODE_LSB 8
`define TC_BIAS_ENA 10
`define TC_REL_IE 11
`define TC_PRS_IE 12
`define TC_CTRL_W 13
// Reset values
`define TC_CTRL_RST 13'h0000
`define TC_ADCSEL_RST 2'h0
// Status bit positions
`define TC_ST_XP 0
`define TC_ST_XN 1
`define TC_ST_PRESS 2
`define TC_ST_REL_EV 3
`define TC_ST_PRS_EV 4
`define TC_ST_CONFLICT 5
`endif

// ===== verilog/touch_ctl_pkg.sv
// Types for the resistive touch matrix control block
package touch_ctl_pkg;
  // Panel mode field
  typedef enum logic [1:0] {
    MODE_INTR = 2'b00,
    MODE_PRESS = 2'b01,
    MODE_POS_A = 2'b10,
    MODE_POS_B = 2'b11
  } panel_mode_t;
  // Converter input route
  typedef enum logic [2:0] {
    ROUTE_XP = 3'b000,
    ROUTE_XN = 3'b001,
    ROUTE_YP = 3'b010,
    ROUTE_YN = 3'b011,
    ROUTE_CUR = 3'b100
  } adc_route_t;
  // Switch state of one terminal
  typedef struct packed {
    logic pow;
    logic gnd;
  } term_sw_t;
  // Switch drive for all four terminals: [0]=x pos,[1]=x neg,[2]=y pos,[3]=y neg
  typedef struct packed {
    term_sw_t [3:0] term;
  } matrix_sw_t;
  // Analog control bundle
  typedef struct packed {
    logic active_bias_en;
    logic pullup_bias_en;
    adc_route_t route;
  } analog_ctl_t;
endpackage : touch_ctl_pkg

// ===== verilog/touch_matrix_ctrl.sv
// Resistive touch panel switch matrix, mode decode and press detect logic
// Requirements behind this block
// [R1] Each terminal floats, powers or grounds per register
// [R2] Power and ground together: terminal is grounded
// [R3] Software powers X, grounds Y for interrupts
// [R4] Interrupt mode biases through pull-up resistor
// [R5] Touch detection keeps working in standby
// [R6] Schmitt outputs detect press, forwarded onward
// [R7] Release rising edge is enableable wake event
// [R8] Detectors sample filtered X terminal signals
// [R9] Any terminal selectable as converter input
// [R10] Bias and converter route follow mode field
// [R11] Software measures X then Y position
// [R12] Y measurement biases Y, senses X
// [R13] Pressure: bias one plate, ground other
// [R14] Plate resistance: other plate left floating
// [R15] Host syncs measurements to display quiet time
// [R16] Mode 00 intr, 01 pressure, 1x position
// [R17] Software disables active bias in interrupt mode
// [R18] Switch outputs registered, never power and ground
// Register map, byte addresses on the APB
//   0x000 control: power and ground requests per terminal in [7:0],
//         mode in [9:8], active bias enable in [10], release and
//         press event enables in [11] and [12], byte-laned writes
//   0x004 converter terminal select in [1:0]
//   0x008 status: synchronised X levels in [1:0], pressed in [2],
//         release and press events in [4:3] (write one to clear),
//         switch conflict in [5]
//   0x00C standby request in [0]
// Timing seen from the bus
//   No wait states; read data is captured in the setup cycle
//   A control write reaches the switch outputs one edge after it lands
//   A detector edge shows in status two edges later, press_det one more
// Hazards
//   Standby leaves the detect path running so a touch can wake the host
//   A double request never reaches a switch: ground wins in the decode
`timescale 1ns/100ps
`include "touch_ctl_cfg.svh"
module touch_matrix_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic x_pos_filt_schmitt,
  input wire logic x_neg_filt_schmitt,
  output touch_ctl_pkg::matrix_sw_t sw_ctl,
  output touch_ctl_pkg::analog_ctl_t analog_ctl,
  output logic standby,
  output logic press_det,
  output logic touch_wake
);
  // Control register and its next value
  logic [`TC_CTRL_W-1:0] ctrl_reg;
  logic [`TC_CTRL_W-1:0] ctrl_next;
  // Converter terminal select
  logic [1:0] adcsel_reg;
  // Standby request
  logic stby_reg;
  // Synchronisers for the Schmitt detector outputs
  logic [1:0] xp_sync_reg;
  logic [1:0] xn_sync_reg;
  // Previous pressed level, for edge detection
  logic press_prev_reg;
  // Sticky event flags
  logic rel_ev_reg;
  logic prs_ev_reg;
  // Registered switch drive and analog control
  touch_ctl_pkg::matrix_sw_t sw_reg;
  touch_ctl_pkg::analog_ctl_t ana_reg;
  // Combined decode
  touch_ctl_pkg::matrix_sw_t sw_next;
  touch_ctl_pkg::analog_ctl_t ana_next;
  touch_ctl_pkg::panel_mode_t mode;
  logic conflict;
  logic pressed;
  logic rel_edge;
  logic prs_edge;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_mux;

  // Resolve one terminal: ground wins on a double request
  function automatic touch_ctl_pkg::term_sw_t resolve(input logic pow, input logic gnd);
    touch_ctl_pkg::term_sw_t t;
    t.gnd = gnd;
    t.pow = pow & ~gnd;
    return t;
  endfunction : resolve

  // Merge byte lanes of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Bus decode: zero-wait slave
  // A write lands at the access edge; the read mux is sampled one edge
  // earlier so the returned word is a flop, not a path through the mux
  // Unmapped addresses answer with an error and change nothing
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;
  always_comb begin
    // Known addresses only
    case (paddr)
      `TC_ADDR_CTRL, `TC_ADDR_ADCSEL, `TC_ADDR_STATUS, `TC_ADDR_STBY: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // Next control value from a byte-enabled write
  always_comb begin
    logic [31:0] m;
    m = merge({{(32-`TC_CTRL_W){1'b0}}, ctrl_reg}, pwdata, pstrb);
    ctrl_next = m[`TC_CTRL_W-1:0];
  end

  // Control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `TC_CTRL_RST;
    end else if (wr_en && paddr == `TC_ADDR_CTRL) begin
      ctrl_reg <= ctrl_next; // [R1]
    end
  end

  // Converter terminal select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adcsel_reg <= `TC_ADCSEL_RST;
    end else if (wr_en && paddr == `TC_ADDR_ADCSEL && pstrb[0]) begin
      adcsel_reg <= pwdata[1:0]; // [R9]
    end
  end

  // Standby register; does not touch the detect path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stby_reg <= 1'b0;
    end else if (wr_en && paddr == `TC_ADDR_STBY && pstrb[0]) begin
      stby_reg <= pwdata[0];
    end
  end

  // Switch matrix decode with conflict resolution
  always_comb begin
    sw_next.term[0] = resolve(ctrl_reg[`TC_XP_POW], ctrl_reg[`TC_XP_GND]); // [R2]
    sw_next.term[1] = resolve(ctrl_reg[`TC_XN_POW], ctrl_reg[`TC_XN_GND]); // [R2]
    sw_next.term[2] = resolve(ctrl_reg[`TC_YP_POW], ctrl_reg[`TC_YP_GND]); // [R2]
    sw_next.term[3] = resolve(ctrl_reg[`TC_YN_POW], ctrl_reg[`TC_YN_GND]); // [R2]
  end
  // Conflict seen on any terminal
  assign conflict = |{ctrl_reg[`TC_XP_POW] & ctrl_reg[`TC_XP_GND],
                      ctrl_reg[`TC_XN_POW] & ctrl_reg[`TC_XN_GND],
                      ctrl_reg[`TC_YP_POW] & ctrl_reg[`TC_YP_GND],
                      ctrl_reg[`TC_YN_POW] & ctrl_reg[`TC_YN_GND]};

  // Mode decode for bias source and converter route
  // The route defaults to the selected terminal and is overridden
  // only by the pressure mode
  assign mode = touch_ctl_pkg::panel_mode_t'(ctrl_reg[`TC_MODE_LSB +: 2]);
  always_comb begin
    ana_next.route = touch_ctl_pkg::adc_route_t'({1'b0, adcsel_reg}); // [R9]
    case (mode)
      touch_ctl_pkg::MODE_INTR: begin
        // Pull-up only; active bias held off whatever the enable says
        ana_next.pullup_bias_en = 1'b1; // [R4] [R16]
        ana_next.active_bias_en = 1'b0; // [R17]
      end
      touch_ctl_pkg::MODE_PRESS: begin
        // Active bias and current monitor input
        ana_next.pullup_bias_en = 1'b0;
        ana_next.active_bias_en = ctrl_reg[`TC_BIAS_ENA]; // [R16]
        ana_next.route = touch_ctl_pkg::ROUTE_CUR; // [R10]
      end
      default: begin
        // Position: active bias and selected terminal
        ana_next.pullup_bias_en = 1'b0;
        ana_next.active_bias_en = ctrl_reg[`TC_BIAS_ENA]; // [R10] [R16]
      end
    endcase
  end

  // Registered switch and analog outputs
  // The switches see only resolved, registered values, so a decode
  // glitch can never short a terminal between supply and ground
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_reg <= '0;
      ana_reg <= '0;
    end else begin
      sw_reg <= sw_next; // [R18]
      ana_reg <= ana_next; // [R10]
    end
  end

  // Synchronise filtered Schmitt outputs; no standby gating
  // Reset to the idle high level so release of reset shows no false press
  // Only the second stage is read anywhere else in the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xp_sync_reg <= 2'b11;
      xn_sync_reg <= 2'b11;
    end else begin
      xp_sync_reg <= {xp_sync_reg[0], x_pos_filt_schmitt}; // [R8] [R5]
      xn_sync_reg <= {xn_sync_reg[0], x_neg_filt_schmitt}; // [R8] [R5]
    end
  end

  // Press when either X terminal falls low, only in interrupt mode
  // Outside interrupt mode the X plate carries measurement voltages,
  // so its level says nothing about a touch and is ignored
  assign pressed = (mode == touch_ctl_pkg::MODE_INTR) &
                   ~(xp_sync_reg[1] & xn_sync_reg[1]); // [R6]
  assign rel_edge = press_prev_reg & ~pressed; // [R7]
  assign prs_edge = ~press_prev_reg & pressed; // [R6]

  // Edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      press_prev_reg <= 1'b0;
    end else begin
      press_prev_reg <= pressed;
    end
  end

  // Sticky events: set wins over write-one-to-clear
  // A clear written in the cycle of a new edge loses, so no event is
  // missed by software that clears and then sleeps
  // A disabled source never sets its flag at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_ev_reg <= 1'b0;
      prs_ev_reg <= 1'b0;
    end else begin
      if (rel_edge && ctrl_reg[`TC_REL_IE]) begin
        rel_ev_reg <= 1'b1; // [R7]
      end else if (wr_en && paddr == `TC_ADDR_STATUS && pwdata[`TC_ST_REL_EV]) begin
        rel_ev_reg <= 1'b0;
      end
      if (prs_edge && ctrl_reg[`TC_PRS_IE]) begin
        prs_ev_reg <= 1'b1; // [R6]
      end else if (wr_en && paddr == `TC_ADDR_STATUS && pwdata[`TC_ST_PRS_EV]) begin
        prs_ev_reg <= 1'b0;
      end
    end
  end

  // Read mux
  // Unused bits read as zero; status bits are live levels apart
  // from the two sticky events
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `TC_ADDR_CTRL: rd_mux[`TC_CTRL_W-1:0] = ctrl_reg;
      `TC_ADDR_ADCSEL: rd_mux[1:0] = adcsel_reg;
      `TC_ADDR_STATUS: begin
        rd_mux[`TC_ST_XP] = xp_sync_reg[1];
        rd_mux[`TC_ST_XN] = xn_sync_reg[1];
        rd_mux[`TC_ST_PRESS] = pressed;
        rd_mux[`TC_ST_REL_EV] = rel_ev_reg;
        rd_mux[`TC_ST_PRS_EV] = prs_ev_reg;
        rd_mux[`TC_ST_CONFLICT] = conflict;
      end
      `TC_ADDR_STBY: rd_mux[0] = stby_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Registered read data, captured in the setup cycle
  // Held until the next read setup, so a slow master still sees it
  // in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      prdata <= rd_mux;
    end
  end

  // Outputs
  assign sw_ctl = sw_reg;
  assign analog_ctl = ana_reg;
  assign standby = stby_reg;
  assign press_det = press_prev_reg; // [R6]
  assign touch_wake = rel_ev_reg | prs_ev_reg; // [R7]
endmodule : touch_matrix_ctrl

// ===== verif/touch_matrix_chk.sv
// Port checker for the touch matrix control block
`timescale 1ns/100ps
module touch_matrix_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic x_pos_filt_schmitt,
  input wire logic x_neg_filt_schmitt,
  input wire touch_ctl_pkg::matrix_sw_t sw_ctl,
  input wire touch_ctl_pkg::analog_ctl_t analog_ctl,
  input wire logic press_det
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_c; // Control register write
  logic [7:0] sv; // Flat switch drive
  assign wr_c = psel && penable && pwrite && paddr == 12'h000 && pstrb == 4'hF;
  assign sv = sw_ctl;
  // Expected drive, a conflicting terminal grounded
  function automatic logic [7:0] rsw(input logic [7:0] c);
    for (int i = 0; i < 8; i += 2)
      rsw[i +: 2] = {c[i] & ~c[i+1], c[i+1]};
  endfunction : rsw
  property p_sw; wr_c |-> ##2 sv == rsw($past(pwdata[7:0], 2)); endproperty
  a_sw: assert property (p_sw) else $error("switch drive mismatch");
  property p_short; (sv & (sv >> 1) & 8'h55) == 8'h00; endproperty
  a_short: assert property (p_short) else $error("terminal powered and grounded");
  property p_intr; wr_c && pwdata[9:8] == 2'b00 |-> ##2 analog_ctl[4:3] == 2'b01; endproperty
  a_intr: assert property (p_intr) else $error("interrupt bias wrong");
  property p_prs;
    wr_c && pwdata[9:8] == 2'b01 |-> ##2
      analog_ctl == {$past(pwdata[10], 2), 1'b0, touch_ctl_pkg::ROUTE_CUR};
  endproperty
  a_prs: assert property (p_prs) else $error("pressure setup wrong");
  property p_pos;
    wr_c && pwdata[9] |-> ##2 analog_ctl[4:3] == {$past(pwdata[10], 2), 1'b0}
      && analog_ctl.route != touch_ctl_pkg::ROUTE_CUR;
  endproperty
  a_pos: assert property (p_pos) else $error("position setup wrong");
  property p_det;
    $rose(press_det) |-> $past(!(x_pos_filt_schmitt && x_neg_filt_schmitt), 3);
  endproperty
  a_det: assert property (p_det) else $error("press without X drop");
  property p_rd; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
  property p_err; psel && penable && paddr > 12'h00C |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
endmodule : touch_matrix_chk
bind touch_matrix_ctrl touch_matrix_chk chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pslverr, .x_pos_filt_schmitt, .x_neg_filt_schmitt,
  .sw_ctl,
  .analog_ctl, .press_det);

// ===== verif/touch_panel_model.sv
// Four-wire panel as seen through the filters and detectors
`timescale 1ns/100ps
module touch_panel_model (
  input wire touch_ctl_pkg::matrix_sw_t sw_ctl,
  input wire logic touched,
  output logic x_pos_filt_schmitt,
  output logic x_neg_filt_schmitt
);
  logic y_gnd; // Y plate held low on either terminal
  assign y_gnd = sw_ctl.term[2].gnd || sw_ctl.term[3].gnd;
  // Pull-up holds X high until contact shorts it to the Y plate
  assign x_pos_filt_schmitt = !(sw_ctl.term[0].gnd || (touched && y_gnd));
  assign x_neg_filt_schmitt = !(sw_ctl.term[1].gnd || (touched && y_gnd));
endmodule : touch_panel_model

// ===== verif/resistive_touch_matrix_control_bench.sv
// Self-checking bench for the touch matrix control block
`timescale 1ns/100ps
module resistive_touch_matrix_control_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, touched = 0;
  logic [11:0] paddr = 12'h000;
  logic [3:0] pstrb = 4'hF; // Byte strobes, full word unless a test narrows them
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, standby, press_det, touch_wake, xp, xn;
  touch_ctl_pkg::matrix_sw_t sw_ctl;
  touch_ctl_pkg::analog_ctl_t analog_ctl;
  int error_cnt = 0, cmp_count = 0;
  always #5 pclk = ~pclk; // 100 MHz
  touch_matrix_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .x_pos_filt_schmitt(xp),
    .x_neg_filt_schmitt(xn), .sw_ctl, .analog_ctl, .standby, .press_det, .touch_wake);
  touch_panel_model panel (.sw_ctl, .touched, .x_pos_filt_schmitt(xp),
    .x_neg_filt_schmitt(xn));
  // Compare and count
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, x, s);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // One APB transfer, result in q and e
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 20);
    chk("pready", pready, 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task t_reset;
    chk("analog", analog_ctl, 32'h08);
    chk("sw", sw_ctl, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", q, 32'h0);
    chk("slverr", e, 1'b0);
  endtask : t_reset
  // Every mode, every converter route, bias on and off
  task t_modes;
    int md, sel, b;
    for (int m = 0; m < 5; m++) begin
      md = (m == 4) ? 2 : m;
      sel = (m == 0) ? 1 : m & 3;
      b = (m != 4);
      apb(1'b1, 12'h004, sel);
      apb(1'b1, 12'h000, (b << 10) | (md << 8));
      tick(1);
      chk("analog", analog_ctl, {md != 0 && b, md == 0, md == 1 ? 3'd4 : 3'(sel)});
    end
  endtask : t_modes
  // Press and release in standby with both events enabled
  task t_touch;
    apb(1'b1, 12'h00C, 32'h1);
    chk("standby", standby, 1'b1);
    apb(1'b1, 12'h000, 32'h18A5);
    touched <= 1'b1;
    tick(6);
    chk("press", press_det, 1'b1);
    chk("wake", touch_wake, 1'b1);
    apb(1'b1, 12'h008, 32'h18);
    apb(1'b0, 12'h008, 32'h0);
    chk("status", q[4:0], 5'h04);
    chk("wake", touch_wake, 1'b0);
    touched <= 1'b0;
    tick(6);
    chk("press", press_det, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk("status", q[4:0], 5'h0B);
    chk("wake", touch_wake, 1'b1);
  endtask : t_touch
  // All four switch codes on all terminals, conflict last
  task t_matrix;
    logic [1:0] x;
    for (int c = 0; c < 4; c++) begin
      x = {c[0] & ~c[1], c[1]};
      apb(1'b1, 12'h000, {22'h0, 2'b10, {4{c[1:0]}}});
      tick(1);
      chk("sw", sw_ctl, {4{x}});
      apb(1'b0, 12'h008, 32'h0);
      chk("conflict", q[5], c == 3);
    end
  endtask : t_matrix
  // One measurement setup: terminal select, control word, then both outputs
  task meas(input logic [1:0] sel, input logic [31:0] c, input logic [7:0] s,
            input logic [4:0] a);
    apb(1'b1, 12'h004, {30'h0, sel});
    apb(1'b1, 12'h000, c);
    tick(1);
    chk("sw", sw_ctl, {24'h0, s});
    chk("analog", analog_ctl, {27'h0, a});
  endtask : meas
  // Host measurement sequences, each set up in an idle bus gap
  task t_measure;
    meas(2'h2, 32'h0000_0609, 8'h06, 5'h12);
    meas(2'h0, 32'h0000_0790, 8'h60, 5'h10);
    meas(2'h0, 32'h0000_05A5, 8'h5A, 5'h14);
    meas(2'h0, 32'h0000_0509, 8'h06, 5'h14);
    pstrb <= 4'h1;
    apb(1'b1, 12'h000, 32'h0000_0000);
    pstrb <= 4'hF;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", q, 32'h0000_0500);
    chk("sw", sw_ctl, 32'h0);
  endtask : t_measure
  // Reset in mid-run, then a touch with both event sources disabled
  task t_rerun;
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(2);
    chk("analog", analog_ctl, 32'h08);
    chk("sw", sw_ctl, 32'h0);
    chk("standby", standby, 1'b0);
    chk("wake", touch_wake, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_00A5);
    touched <= 1'b1;
    tick(6);
    chk("press", press_det, 1'b1);
    chk("wake", touch_wake, 1'b0);
    touched <= 1'b0;
    tick(6);
    chk("press", press_det, 1'b0);
    chk("wake", touch_wake, 1'b0);
  endtask : t_rerun
  task t_unmapped;
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", e, 1'b1);
    chk("rdata", q, 32'h0);
  endtask : t_unmapped
  task summarize;
    $display("mismatches %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Main sequence after reset
  initial begin
    tick(6);
    presetn <= 1'b1;
    tick(2);
    t_reset();
    t_modes();
    t_touch();
    t_matrix();
    t_measure();
    t_rerun();
    t_unmapped();
    summarize();
  end
  // Watchdog against a hung handshake
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule : resistive_touch_matrix_control_bench
